// ### rtl/smc_pkg.sv
package smc_pkg;
  // Timing at 50 MHz
  localparam int CLK_HZ = 50_000_000;
  localparam int LONG_OPEN_WINDOW_MS = 200;
  localparam int LONG_OPEN_WINDOW_CYC = LONG_OPEN_WINDOW_MS * (CLK_HZ / 1000);
  localparam int RESET_DELAY_TIME_US = 10;
  localparam int RESET_DELAY_TIME_CYC = RESET_DELAY_TIME_US * (CLK_HZ / 1_000_000);
  localparam int CFG_FILTER_CYC = 4;

  // Mode field encodings as written and read back by the host
  localparam logic [2:0] MODE_FIELD_NORMAL = 3'h0;
  localparam logic [2:0] MODE_FIELD_SLEEP = 3'h1;
  localparam logic [2:0] MODE_FIELD_STOP = 3'h2;
  localparam logic [2:0] MODE_FIELD_SOFT_RESET = 3'h3;

  // Bit positions of the status pair in the wake level status register
  localparam int STAT_REACTION_BIT = 0;
  localparam int STAT_COUNT_BIT = 1;

  typedef enum logic [2:0] {
    SMC_INIT,
    SMC_NORMAL,
    SMC_STOP,
    SMC_SLEEP,
    SMC_RESTART,
    SMC_FAILSAFE
  } smc_mode_t;

  // Latched power-up configuration
  typedef struct packed {
    logic supply_gnd;
    logic reaction_strap_state;
    logic debug;
  } smc_cfg_t;

  // Fault and wake events from the rest of the chip
  typedef struct packed {
    logic wake;
    logic wd_fail;
    logic io_overvoltage_flag;
    logic io_undervoltage;
    logic thermal_shutdown_level2;
  } smc_evt_t;
endpackage

// ### rtl/smc_cfg_latch.sv
`timescale 1ns/1ps
module smc_cfg_latch #(
  parameter int FILTER_CYC = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic capture,
  input wire logic level_in,
  output logic level_out
);
  import smc_pkg::*;

  logic [7:0] stable_cnt;
  logic last;
  wire same = (level_in == last);
  wire filtered_ok = (stable_cnt >= 8'(FILTER_CYC));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      last <= 1'b0;
      stable_cnt <= 8'h00;
    end else begin
      last <= level_in;
      if (!same) begin
        stable_cnt <= 8'h00;
      end else if (!filtered_ok) begin
        stable_cnt <= stable_cnt + 8'h01;
      end
    end
  end

  // Only power-on reset clears the stored value
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      level_out <= 1'b0;
    end else if (capture && filtered_ok) begin
      level_out <= last;
    end
  end
endmodule

// ### rtl/smc_delay_timer.sv
`timescale 1ns/1ps
module smc_delay_timer #(
  parameter int CYCLES = 500
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic run,
  output logic done
);
  import smc_pkg::*;

  logic [31:0] cnt;
  wire at_end = (cnt >= 32'(CYCLES - 1));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 32'h0000_0000;
      done <= 1'b0;
    end else if (!run) begin
      cnt <= 32'h0000_0000;
      done <= 1'b0;
    end else if (!at_end) begin
      cnt <= cnt + 32'h0000_0001;
    end else begin
      done <= 1'b1;
    end
  end
endmodule

// ### rtl/smc_mode_ctrl.sv
`timescale 1ns/1ps
// Contract
// R1 - Six modes: init, normal, stop, sleep, restart, fail-safe; exactly one active.
// R2 - Init mode entered at power-up and after soft reset command.
// R3 - Restart after wake or failure; leaves to normal after reset delay, failure gone.
// R4 - Critical failures like level-2 thermal shutdown go fail-safe; buck off there.
// R5 - Stop keeps main regulator on; sleep turns buck off.
// R6 - Debug variant: all modes reachable, watchdog counter halted.
// R7 - Debug chosen when test pin held low throughout init mode; the code looks at the pin only until the straps are latched.
// R8 - Host writes mode field over SPI; device acts on it.
// R9 - Mode field cleared when passing restart, so it shows current mode.
// R10 - Start in init; long open window begins after reset output release.
// R11 - Supply strap sampled at power-up, kept until power-on reset.
// R12 - Strap open: external rail software controlled, off at start, undervoltage flag active.
// R13 - Strap grounded: external rail fixed 3.3 V following main regulator.
// R14 - Configs 1 and 3: watchdog failure gives restart; fail output per count bit.
// R15 - Configs 2 and 4: watchdog failure gives fail-safe; config 4 first gives restart.
// R16 - Overvoltage reset enabled, configs 1/3: overvoltage gives restart and fail output.
// R17 - Overvoltage reset enabled, configs 2/4: overvoltage gives fail-safe and fail output.
// R18 - Latched reaction configuration readable as two status bits.
// R19 - Pull-up reads 1 for restart; open reads 0; second bit mirrors count bit.
// R20 - Config 2 first missed trigger: main regulator off, fail output, fail-safe.
// R21 - Debug: watchdog failure causes no reset; host sends one SPI command.
// R22 - Pull interrupt pin weakly low in reset delay; latch at reset release.
// R23 - Latched configuration cleared only by power-on reset.
module smc_mode_ctrl #(
  parameter int LONG_WINDOW_CYC = smc_pkg::LONG_OPEN_WINDOW_CYC,
  parameter int RESET_DELAY_CYC = smc_pkg::RESET_DELAY_TIME_CYC,
  parameter int FILTER_CYC = smc_pkg::CFG_FILTER_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic spi_write,
  input wire logic [2:0] mode_field_wr,
  input wire logic failure_count_sel,
  input wire logic overvoltage_reset_en,
  input wire logic external_rail_en_sw,
  input wire logic supply_strap_pin,
  input wire logic irq_in,
  input wire logic test_pin,
  input wire smc_pkg::smc_evt_t evt,
  output smc_pkg::smc_mode_t mode,
  output logic [2:0] mode_field,
  output logic reset_out_n,
  output logic irq_pulldown_oe_n,
  output logic fail_output,
  output logic main_regulator_on,
  output logic external_rail_on,
  output logic external_rail_voltage_sel,
  output logic regulator_undervoltage_flag,
  output logic [1:0] wake_level_status_reg,
  output logic debug_mode,
  output logic long_window_active,
  output logic watchdog_halted
);
  import smc_pkg::*;

  // ---------------------------------------------------------------
  // Configuration capture
  // ---------------------------------------------------------------
  smc_mode_t state;
  smc_mode_t next_state;
  smc_cfg_t cfg;
  logic supply_gnd;
  logic reaction_strap_state;
  logic debug_seen_high;
  logic cfg_done;
  logic delay_done;
  logic [1:0] wd_fail_cnt;
  logic [31:0] window_cnt;
  logic first_cmd_seen;

  wire in_init = (state == SMC_INIT);
  wire in_restart = (state == SMC_RESTART);
  wire release_edge = (in_init || in_restart) && delay_done;
  // Capture only once per power-on; a soft reset does not re-latch
  wire cfg_capture = release_edge && !cfg_done;

  smc_cfg_latch #(.FILTER_CYC(FILTER_CYC)) u_reaction_latch (
    .core_clk(core_clk),
    .resetn(resetn),
    .capture(cfg_capture),
    .level_in(irq_in),
    .level_out(reaction_strap_state)
  ); // R22

  // Timer restarts on every entry, also on a direct step from init to restart
  wire timer_run = (in_init || in_restart) && (next_state == state);

  smc_delay_timer #(.CYCLES(RESET_DELAY_CYC)) u_reset_delay (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(timer_run),
    .done(delay_done)
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      supply_gnd <= 1'b0;
      cfg_done <= 1'b0;
    end else if (!cfg_done) begin
      supply_gnd <= !supply_strap_pin; // R11
      cfg_done <= cfg_capture; // R23
    end
  end

  // A high on the test pin in init before the straps are latched disqualifies debug
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      debug_seen_high <= 1'b0;
    end else if (in_init && !cfg_done && test_pin) begin
      debug_seen_high <= 1'b1; // R7
    end
  end

  assign cfg.supply_gnd = supply_gnd;
  assign cfg.reaction_strap_state = reaction_strap_state;
  assign cfg.debug = cfg_done && !debug_seen_high;

  // ---------------------------------------------------------------
  // Fault decoding
  // ---------------------------------------------------------------
  wire restart_cfg = cfg.reaction_strap_state;
  wire single_cfg = failure_count_sel;
  wire wd_event = evt.wd_fail && !cfg.debug && !in_init; // R21
  wire init_timeout = in_init && cfg_done && !cfg.debug && !first_cmd_seen &&
                      (window_cnt >= 32'(LONG_WINDOW_CYC - 1));
  wire wd_any = wd_event || init_timeout;
  wire ov_event = evt.io_overvoltage_flag && overvoltage_reset_en &&
                  (state == SMC_NORMAL || state == SMC_STOP);
  // Config 4 sends only the first failure to restart
  wire wd_to_failsafe = !restart_cfg && (single_cfg || wd_fail_cnt != 2'h0); // R15
  wire wd_fo = single_cfg || (wd_fail_cnt != 2'h0); // R14
  wire crit_event = evt.thermal_shutdown_level2; // R4
  wire wake_event = evt.wake && (state == SMC_SLEEP || state == SMC_FAILSAFE);
  wire uv_event = evt.io_undervoltage && (state == SMC_NORMAL || state == SMC_STOP);

  // ---------------------------------------------------------------
  // Mode state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (crit_event) begin
      next_state = SMC_FAILSAFE; // R4
    end else if (ov_event) begin
      next_state = restart_cfg ? SMC_RESTART : SMC_FAILSAFE; // R16 R17
    end else if (wd_any && (state != SMC_FAILSAFE)) begin
      next_state = wd_to_failsafe ? SMC_FAILSAFE : SMC_RESTART; // R14 R15 R20
    end else begin
      case (state)
        SMC_INIT: begin
          if (spi_write && delay_done) begin
            next_state = SMC_NORMAL;
          end
        end
        SMC_NORMAL, SMC_STOP: begin
          if (uv_event) begin
            next_state = SMC_RESTART;
          end else if (spi_write) begin // R8
            if (mode_field_wr == MODE_FIELD_SOFT_RESET) begin
              next_state = SMC_INIT; // R2
            end else if (mode_field_wr == MODE_FIELD_STOP) begin
              next_state = SMC_STOP;
            end else if (mode_field_wr == MODE_FIELD_SLEEP) begin
              // Stop cannot go straight to sleep
              next_state = (state == SMC_STOP) ? SMC_RESTART : SMC_SLEEP;
            end else if (mode_field_wr == MODE_FIELD_NORMAL) begin
              next_state = SMC_NORMAL;
            end
          end
        end
        SMC_SLEEP, SMC_FAILSAFE: begin
          if (wake_event) begin
            next_state = SMC_RESTART; // R3
          end
        end
        SMC_RESTART: begin
          if (delay_done && !evt.io_undervoltage) begin
            next_state = SMC_NORMAL; // R3
          end
        end
        default: next_state = SMC_INIT;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= SMC_INIT; // R2 R10
    end else begin
      state <= next_state; // R1
    end
  end

  // Readback code of a mode; init, restart and fail-safe all read as normal
  function automatic logic [2:0] field_of(input smc_mode_t m);
    logic [2:0] f;
    f = MODE_FIELD_NORMAL;
    if (m == SMC_SLEEP) begin
      f = MODE_FIELD_SLEEP;
    end else if (m == SMC_STOP) begin
      f = MODE_FIELD_STOP;
    end
    return f;
  endfunction

  // Field follows the mode taken, not the raw request, so a refused or
  // redirected write never shows a mode the device is not in
  wire [2:0] next_field = field_of(next_state);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_field <= MODE_FIELD_NORMAL;
    end else begin
      mode_field <= next_field; // R8 R9
    end
  end

  // ---------------------------------------------------------------
  // Watchdog failure count, fail output and long window
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wd_fail_cnt <= 2'h0;
      fail_output <= 1'b0;
    end else begin
      if (wd_any && state != SMC_FAILSAFE && wd_fail_cnt != 2'h3) begin
        wd_fail_cnt <= wd_fail_cnt + 2'h1;
      end
      // Restart entry on wake or undervoltage, and restart exit, leave the fail output as it is
      if ((wd_any && state != SMC_FAILSAFE && wd_fo) || ov_event) begin
        fail_output <= 1'b1; // R14 R16 R17 R20
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      window_cnt <= 32'h0000_0000;
      first_cmd_seen <= 1'b0;
    end else if (!in_init || !delay_done || cfg.debug) begin
      window_cnt <= 32'h0000_0000; // R6 R10
      first_cmd_seen <= 1'b0;
    end else begin
      window_cnt <= window_cnt + 32'h0000_0001;
      if (spi_write) begin
        first_cmd_seen <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign mode = state;
  assign reset_out_n = !((in_init || in_restart) && !delay_done) && (state != SMC_SLEEP);
  assign irq_pulldown_oe_n = !((in_init || in_restart) && !delay_done && !cfg_done); // R22
  assign main_regulator_on = (state != SMC_SLEEP) && (state != SMC_FAILSAFE); // R4 R5 R20
  assign external_rail_on = cfg.supply_gnd ? main_regulator_on :
                            (external_rail_en_sw && cfg_done); // R12 R13
  assign external_rail_voltage_sel = cfg.supply_gnd; // R13
  assign regulator_undervoltage_flag = !cfg.supply_gnd; // R12 R13
  assign wake_level_status_reg[STAT_REACTION_BIT] = cfg.reaction_strap_state; // R18 R19
  assign wake_level_status_reg[STAT_COUNT_BIT] = failure_count_sel; // R19
  assign debug_mode = cfg.debug;
  assign watchdog_halted = cfg.debug; // R6
  assign long_window_active = in_init && delay_done && !cfg.debug; // R10

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Host request with nothing of higher priority in the same cycle
  wire host_req_ok = spi_write && !crit_event && !ov_event && !wd_any && !uv_event;

  sequence s_restart_done;
    in_restart && delay_done && !evt.io_undervoltage && !crit_event && !ov_event && !wd_any;
  endsequence

  sequence s_soft_reset_req;
    host_req_ok && (state == SMC_NORMAL || state == SMC_STOP) &&
      mode_field_wr == MODE_FIELD_SOFT_RESET;
  endsequence

  sequence s_stop_sleep_req;
    host_req_ok && state == SMC_STOP && mode_field_wr == MODE_FIELD_SLEEP;
  endsequence

  sequence s_wd_fail;
    wd_any && state != SMC_FAILSAFE && !crit_event && !ov_event;
  endsequence

  a_one_mode: assert property (@(posedge core_clk) disable iff (!resetn) // R1
    state inside {SMC_INIT, SMC_NORMAL, SMC_STOP, SMC_SLEEP, SMC_RESTART, SMC_FAILSAFE})
    else $error("mode out of range");
  a_restart_exit: assert property (@(posedge core_clk) disable iff (!resetn) // R3
    s_restart_done |=> state == SMC_NORMAL) else $error("restart did not exit");
  a_restart_delay: assert property (@(posedge core_clk) disable iff (!resetn) // R3
    $rose(in_restart) |-> !delay_done) else $error("restart without reset delay");
  a_wake_restart: assert property (@(posedge core_clk) disable iff (!resetn) // R3
    wake_event && !crit_event && !wd_any |=> in_restart) else $error("wake did not restart");
  a_soft_reset_init: assert property (@(posedge core_clk) disable iff (!resetn) // R2
    s_soft_reset_req |=> in_init) else $error("soft reset missed");
  a_init_refuse: assert property (@(posedge core_clk) disable iff (!resetn) // R10
    in_init && !delay_done && !crit_event |=> in_init) else $error("init left early");
  a_init_exit: assert property (@(posedge core_clk) disable iff (!resetn) // R8
    in_init && delay_done && host_req_ok |=> state == SMC_NORMAL) else $error("init kept");
  a_stop_sleep: assert property (@(posedge core_clk) disable iff (!resetn) // R8
    s_stop_sleep_req |=> in_restart) else $error("stop to sleep not via restart");
  a_field_stop: assert property (@(posedge core_clk) disable iff (!resetn) // R8 R9
    (state == SMC_STOP) == (mode_field == MODE_FIELD_STOP)) else $error("field not mode");
  a_mode_clear: assert property (@(posedge core_clk) disable iff (!resetn) // R9
    in_restart |-> mode_field == MODE_FIELD_NORMAL) else $error("mode field kept");
  a_crit_failsafe: assert property (@(posedge core_clk) disable iff (!resetn) // R4
    crit_event |=> state == SMC_FAILSAFE) else $error("critical failure not failsafe");
  a_failsafe_buck: assert property (@(posedge core_clk) disable iff (!resetn) // R4
    state == SMC_FAILSAFE |-> !main_regulator_on) else $error("buck on in failsafe");
  a_stop_reg_on: assert property (@(posedge core_clk) disable iff (!resetn) // R5
    state == SMC_STOP |-> main_regulator_on) else $error("regulator off in stop");
  a_sleep_buck_off: assert property (@(posedge core_clk) disable iff (!resetn) // R5
    state == SMC_SLEEP |-> !main_regulator_on && !reset_out_n)
    else $error("buck on in sleep");
  a_debug_halt: assert property (@(posedge core_clk) disable iff (!resetn) // R6
    cfg.debug |-> watchdog_halted && !long_window_active) else $error("debug watchdog runs");
  a_debug_no_reset: assert property (@(posedge core_clk) disable iff (!resetn) // R21
    cfg.debug && evt.wd_fail && !crit_event && !ov_event && !uv_event && state == SMC_NORMAL
    |=> state != SMC_RESTART) else $error("debug reset on wd");
  a_wd_target: assert property (@(posedge core_clk) disable iff (!resetn) // R14 R15 R20
    s_wd_fail |=> (state == SMC_FAILSAFE) == $past(wd_to_failsafe))
    else $error("wd reaction wrong");
  a_wd_fail_out: assert property (@(posedge core_clk) disable iff (!resetn) // R14
    s_wd_fail ##0 wd_fo |=> fail_output) else $error("fail output missed");
  a_fail_sticky: assert property (@(posedge core_clk) disable iff (!resetn) // R14
    fail_output |=> fail_output) else $error("fail output dropped");
  a_ov_fail_out: assert property (@(posedge core_clk) disable iff (!resetn) // R16 R17
    ov_event && !crit_event |=> fail_output && (state == SMC_RESTART) == restart_cfg)
    else $error("ov reaction wrong");
  a_irq_pull: assert property (@(posedge core_clk) disable iff (!resetn) // R22
    !irq_pulldown_oe_n |-> !reset_out_n) else $error("pull-down after release");
  a_cfg_hold: assert property (@(posedge core_clk) disable iff (!resetn) // R23
    cfg_done |=> $stable(reaction_strap_state) && $stable(supply_gnd))
    else $error("config changed");
  a_rail_follow: assert property (@(posedge core_clk) disable iff (!resetn) // R13
    cfg.supply_gnd |-> external_rail_on == main_regulator_on) else $error("rail mismatch");
  a_rail_open: assert property (@(posedge core_clk) disable iff (!resetn) // R12
    cfg_done && !cfg.supply_gnd |-> external_rail_on == external_rail_en_sw)
    else $error("open rail not software");
endmodule

// ### verification/smc_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host microcontroller on the SPI and strap pins
// ----------------------------------------
module smc_host_model (
  input wire logic core_clk,
  input wire logic in_init,
  input wire logic pull_up,
  input wire logic debug_req,
  output logic spi_write,
  output logic [2:0] mode_field_wr,
  output logic irq_in,
  output logic test_pin
);
  initial begin
    spi_write = 1'b0;
    mode_field_wr = 3'h0;
  end
  // Test pin held low for the whole init phase when debug is wanted
  assign test_pin = !(debug_req && in_init);
  // A strong external pull-up wins over the weak internal pull-down
  assign irq_in = pull_up;
  // One whole frame; the field is scrambled once the frame is over
  task automatic send(input logic [2:0] v);
    @(negedge core_clk);
    spi_write = 1'b1;
    mode_field_wr = v;
    @(negedge core_clk);
    spi_write = 1'b0;
    mode_field_wr = ~v;
  endtask
endmodule

// ### verification/test_mode_field_config_control.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module test_mode_field_config_control;
  import smc_pkg::*;
  logic core_clk, resetn, fcs, ove, ext_sw, strap, pull_up, dbg;
  logic spi_write, irq_in, test_pin, reset_out_n, irq_pulldown_oe_n, fail_output;
  logic main_regulator_on, external_rail_on, external_rail_voltage_sel;
  logic regulator_undervoltage_flag, debug_mode, long_window_active, watchdog_halted;
  logic [2:0] mode_field_wr, mode_field;
  logic [1:0] wake_level_status_reg;
  smc_evt_t evt, wd, ov;
  smc_mode_t mode;
  int miscompares, checked, k, c, off;
  logic pu, cs;
  smc_mode_ctrl #(.LONG_WINDOW_CYC(200), .RESET_DELAY_CYC(20), .FILTER_CYC(4)) smc_mode_ctrl_inst (
    .core_clk(core_clk), .resetn(resetn), .spi_write(spi_write),
    .mode_field_wr(mode_field_wr), .failure_count_sel(fcs), .overvoltage_reset_en(ove),
    .external_rail_en_sw(ext_sw), .supply_strap_pin(strap), .irq_in(irq_in),
    .test_pin(test_pin), .evt(evt), .mode(mode), .mode_field(mode_field),
    .reset_out_n(reset_out_n), .irq_pulldown_oe_n(irq_pulldown_oe_n),
    .fail_output(fail_output), .main_regulator_on(main_regulator_on),
    .external_rail_on(external_rail_on), .external_rail_voltage_sel(external_rail_voltage_sel),
    .regulator_undervoltage_flag(regulator_undervoltage_flag),
    .wake_level_status_reg(wake_level_status_reg), .debug_mode(debug_mode),
    .long_window_active(long_window_active), .watchdog_halted(watchdog_halted));
  smc_host_model smc_host_model_inst (
    .core_clk(core_clk), .in_init(mode === SMC_INIT), .pull_up(pull_up), .debug_req(dbg),
    .spi_write(spi_write), .mode_field_wr(mode_field_wr), .irq_in(irq_in),
    .test_pin(test_pin));
  // ----------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #400_000;
    miscompares++;
    end_of_test();
  end
  task automatic end_of_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic pulse(input smc_evt_t e);
    @(negedge core_clk);
    evt = e;
    @(negedge core_clk);
    evt = '0;
  endtask
  task automatic wait_mode(input smc_mode_t m, input int n);
    int i;
    for (i = 0; i < n && mode !== m; i++) @(negedge core_clk);
    `CHK(mode, m)
  endtask
  task automatic power_up(input logic u, input logic s, input logic g, input logic d);
    int i;
    @(negedge core_clk);
    resetn = 1'b0;
    {pull_up, fcs, strap, dbg, ove, evt} = {u, s, g, d, 1'b0, 5'h00};
    repeat (20) @(negedge core_clk);
    `CHK(mode, SMC_INIT)
    `CHK({reset_out_n, fail_output, mode_field}, 5'h00)
    `CHK(irq_pulldown_oe_n, 1'b0)
    resetn = 1'b1;
    for (i = 0; i < 40 && reset_out_n !== 1'b1; i++) @(negedge core_clk);
    `CHK(reset_out_n, 1'b1)
    // Straps are taken one clock after the reset output rises
    @(negedge core_clk);
    `CHK(irq_pulldown_oe_n, 1'b1)
    `CHK(mode, SMC_INIT)
    `CHK(wake_level_status_reg, {s, u})
    `CHK(external_rail_voltage_sel, !g)
    `CHK(regulator_undervoltage_flag, g)
    `CHK(external_rail_on, !g)
    `CHK({debug_mode, watchdog_halted}, {d, d})
    if (!d) `CHK(long_window_active, 1'b1)
    if (g) begin
      ext_sw = 1'b1;
      @(negedge core_clk);
      `CHK(external_rail_on, 1'b1)
      ext_sw = 1'b0;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {resetn, fcs, ove, ext_sw, strap, pull_up, dbg, evt} = '0;
    miscompares = 0;
    checked = 0;
    wd = '0;
    wd.wd_fail = 1'b1;
    ov = '0;
    ov.io_overvoltage_flag = 1'b1;
    void'($urandom(32'h514a));
    off = $urandom % 4;
    // Four watchdog configurations, then the same four for overvoltage
    for (k = 0; k < 8; k++) begin
      c = (k + off) % 4;
      pu = ~c[0];
      cs = ~c[1];
      power_up(pu, cs, 1'($urandom), 1'b0);
      smc_host_model_inst.send(3'($urandom));
      `CHK(mode, SMC_NORMAL)
      smc_host_model_inst.send(MODE_FIELD_STOP);
      `CHK({mode, mode_field, main_regulator_on}, {SMC_STOP, MODE_FIELD_STOP, 1'b1})
      if (k == 0) begin
        smc_host_model_inst.send(MODE_FIELD_NORMAL);
        smc_host_model_inst.send(MODE_FIELD_SLEEP);
        `CHK({mode, main_regulator_on, reset_out_n}, {SMC_SLEEP, 2'b00})
        pulse(5'h10);
        `CHK({mode, mode_field}, {SMC_RESTART, 3'h0})
        wait_mode(SMC_NORMAL, 60);
        `CHK(reset_out_n, 1'b1)
      end else begin
        // Stop cannot go straight to sleep; it passes through restart
        smc_host_model_inst.send(k == 1 ? MODE_FIELD_SLEEP : MODE_FIELD_NORMAL);
        if (k == 1) begin
          `CHK({mode, mode_field}, {SMC_RESTART, MODE_FIELD_NORMAL})
          wait_mode(SMC_NORMAL, 60);
        end
        if (k == 2) begin
          pulse(ov);
          `CHK({mode, fail_output}, {SMC_NORMAL, 1'b0})
          pulse(5'h02);
          `CHK(mode, SMC_RESTART)
          wait_mode(SMC_NORMAL, 60);
        end
      end
      if (k >= 4) begin
        ove = 1'b1;
        pulse(ov);
        `CHK(mode, pu ? SMC_RESTART : SMC_FAILSAFE)
        `CHK(fail_output, 1'b1)
      end else begin
        if (!cs) begin
          pulse(wd);
          `CHK({mode, mode_field, fail_output}, {SMC_RESTART, 4'h0})
          wait_mode(SMC_NORMAL, 60);
        end
        pulse(wd);
        `CHK(mode, pu ? SMC_RESTART : SMC_FAILSAFE)
        `CHK(fail_output, 1'b1)
        `CHK(main_regulator_on, pu)
      end
    end
    // Missing first write in init, then soft reset keeps the latched straps
    power_up(1'b1, 1'b1, 1'b0, 1'b0);
    wait_mode(SMC_RESTART, 260);
    wait_mode(SMC_NORMAL, 60);
    @(negedge core_clk);
    pull_up = 1'b0;
    smc_host_model_inst.send(MODE_FIELD_SOFT_RESET);
    `CHK(mode, SMC_INIT)
    `CHK(wake_level_status_reg, 2'h3)
    `CHK(reset_out_n, 1'b0)
    // Writes are refused until the reset delay has run out
    repeat (21) @(negedge core_clk);
    `CHK(reset_out_n, 1'b1)
    smc_host_model_inst.send(MODE_FIELD_STOP);
    `CHK(mode, SMC_NORMAL)
    pulse(5'h01);
    `CHK({mode, main_regulator_on}, {SMC_FAILSAFE, 1'b0})
    // Debug configuration ignores watchdog failures
    power_up(1'b0, 1'b1, 1'b0, 1'b1);
    smc_host_model_inst.send(3'($urandom));
    pulse(wd);
    `CHK({mode, fail_output}, {SMC_NORMAL, 1'b0})
    smc_host_model_inst.send(MODE_FIELD_STOP);
    `CHK(mode, SMC_STOP)
    end_of_test();
  end
endmodule
